// [hdl/ocft_map.vh]
`ifndef OCFT_MAP_VH
`define OCFT_MAP_VH
// Register byte addresses on the AXI4-Lite slave
`define OCFT_ADDR_CON2     8'h00
`define OCFT_ADDR_STATUS   8'h04
`define OCFT_ADDR_MASK     8'h08
`define OCFT_ADDR_CTRL     8'h0C
// Field positions in the second control register
`define OCFT_BIT_FAULT_HOLD_MODE     15
`define OCFT_BIT_FAULT_DRIVE_LEVEL    14
`define OCFT_BIT_FLTTRI    13
`define OCFT_BIT_INV       12
`define OCFT_BIT_CASCADE   8
`define OCFT_BIT_TRIGSEL   7
`define OCFT_BIT_TIMER_TRIGGER_STATUS  6
`define OCFT_BIT_TRIS      5
`define OCFT_SEL_MSB       4
// Writable bits of the second control register (status bit excluded)
`define OCFT_CON2_WMASK    16'hF1BF
// Power-on value: two middle source select bits set
`define OCFT_CON2_RESET    16'h000C
// Status and mask bit positions
`define OCFT_EV_FAULT      0
`define OCFT_EV_TRIG       1
`define OCFT_EV_OFF        2
`define OCFT_EV_BITS       3
// Control register bits
`define OCFT_BIT_ENABLE    0
`define OCFT_BIT_FLAGCLR   1
// AXI response codes
`define OCFT_RESP_OKAY     2'h0
`define OCFT_RESP_SLVERR   2'h2
`endif

// [hdl/ocft_core.v]
`timescale 1ns/1ps
`include "ocft_map.vh"

// Summary of operation
// R1 - Hold fault until source gone, flag cleared
// R2 - Fault drives tri-state, high or low
// R3 - Select bit picks trigger or sync mode
// R4 - Status set when triggered; timer held otherwise
// R5 - Direction bit tri-states the compare pin
// R6 - Software never selects channel as own source
// R7 - Emit trigger-out when channel turns off
// R8 - Software deselects source before disabling it
// R9 - Source select low bits, resets to 000C
module ocft_core #(
  parameter NSRC = 32,                    // Number of selectable sources
  parameter TW   = 16                     // Timebase width
) (
  input  wire             aclk,           // Peripheral clock
  input  wire             aresetn,        // Synchronous reset, active low
  input  wire             ce,             // Clock enable, freezes state when low
  // AXI4-Lite write address, data and response channels
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output reg              s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output reg              s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  // AXI4-Lite read address and data channels
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output reg              s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  // Channel pins and timebase settings
  input  wire             fault_in,       // Fault source pin, asynchronous
  input  wire [NSRC-1:0]  source_pulse,   // Trigger/sync pulses from same clock
  input  wire [TW-1:0]    period,         // Timebase period, last count
  input  wire [TW-1:0]    duty,           // Compare value for pulse width
  // Compare pin, cross-channel trigger and status
  output reg              compare_out,    // Compare pin output level
  output reg              compare_oe,     // High while the pin is driven
  output reg              trigger_out,    // One-cycle pulse when channel turns off
  output reg  [TW-1:0]    timer_count,    // Channel timebase
  output reg              irq             // Level interrupt
);

  // Fault pin synchroniser, three stages
  reg  [2:0]      fault_sync;
  reg             fault_seen;             // Debounced fault level
  // Registers
  reg  [15:0]     control_2;              // Second control register
  reg  [`OCFT_EV_BITS-1:0] status;        // Sticky events
  reg  [`OCFT_EV_BITS-1:0] mask;          // Interrupt enables
  reg             enable;                 // Channel on
  reg             channel_fault_flag;     // Fault latch, software cleared
  reg             fault_mode;             // Output overridden
  reg             timer_trigger_status;   // Timebase running in trigger mode
  // AXI write capture
  reg             aw_held;
  reg             w_held;
  reg  [7:0]      aw_addr;
  reg  [31:0]     w_data;
  reg  [3:0]      w_strb;

  // Decoded strobes and events, all in the same cycle
  // A write completes once both halves are held and no response is pending
  wire            do_write   = aw_held & w_held & ~s_axi_bvalid;
  wire            trig_sel   = control_2[`OCFT_BIT_TRIGSEL];
  wire [4:0]      sel        = control_2[`OCFT_SEL_MSB:0];
  // Source pulse picked by the select field
  wire            src_hit    = source_pulse[sel];
  // End of a period is the last count
  wire            period_end = (timer_count == period);
  // Control writes: bit 1 clears the fault flag, bit 0 sets the enable
  wire            flag_clr   = do_write & (aw_addr == `OCFT_ADDR_CTRL) & w_strb[0]
                               & w_data[`OCFT_BIT_FLAGCLR];
  wire            en_wr      = do_write & (aw_addr == `OCFT_ADDR_CTRL) & w_strb[0];
  wire            next_en    = en_wr ? w_data[`OCFT_BIT_ENABLE] : enable;
  // Event pulses feeding the sticky status register
  wire            fault_evt  = fault_seen & ~channel_fault_flag;
  wire            trig_evt   = enable & trig_sel & ~timer_trigger_status & src_hit;
  // Off event fires on the edge at which the enable bit drops
  wire            off_evt    = enable & ~next_en;

  // Byte-lane merge for 16-bit registers
  function [15:0] lane_merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      lane_merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  // Synchronise the fault pin; stages 2 and 3 must agree before it counts
  always @(posedge aclk) begin
    if (!aresetn) begin
      fault_sync <= 3'h0;
      fault_seen <= 1'b0;
    end else if (ce) begin
      fault_sync <= {fault_sync[1:0], fault_in};
      // A one-cycle glitch on the pin is ignored, at the cost of one more
      // cycle of latency before the fault response starts
      if (fault_sync[1] == fault_sync[2])
        fault_seen <= fault_sync[2];
    end
  end

  // AXI write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `OCFT_RESP_OKAY;
    end else if (ce) begin
      // Ready pulses for one cycle, so each channel takes exactly one item
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      // Address half
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      // Data half with its byte strobes
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        // Response follows both halves
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr > `OCFT_ADDR_CTRL || aw_addr[1:0] != 2'h0)
                        ? `OCFT_RESP_SLVERR : `OCFT_RESP_OKAY;
      end else if (s_axi_bvalid & s_axi_bready) begin
        // Response stood until the master took it
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read channel, one read at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `OCFT_RESP_OKAY;
    end else if (ce) begin
      // No new address is taken while a response still stands
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `OCFT_RESP_OKAY;
        // Data picked from the address the master still holds
        case (s_axi_araddr)
          `OCFT_ADDR_CON2:   s_axi_rdata <= {16'h0000, control_2};
          `OCFT_ADDR_STATUS: s_axi_rdata <= {29'h0, status};
          `OCFT_ADDR_MASK:   s_axi_rdata <= {29'h0, mask};
          `OCFT_ADDR_CTRL:   s_axi_rdata <= {29'h0, fault_mode, channel_fault_flag, enable};
          default: begin
            // Unmapped address answers zero with an error
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `OCFT_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        // Data taken, channel free again
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Register file; the trigger status bit is only written by hardware
  always @(posedge aclk) begin
    if (!aresetn) begin
      control_2 <= `OCFT_CON2_RESET; // R9
      mask      <= 3'h0;
      enable    <= 1'b0;
    end else if (ce) begin
      // Writes merge per byte lane; unimplemented and status bits keep their
      // value, so software cannot fake the trigger status
      if (do_write && aw_addr == `OCFT_ADDR_CON2)
        control_2 <= (lane_merge(control_2, w_data, w_strb) & `OCFT_CON2_WMASK)
                     | (control_2 & ~`OCFT_CON2_WMASK);
      else
        // Status bit copies the timebase flag one cycle late
        control_2[`OCFT_BIT_TIMER_TRIGGER_STATUS] <= timer_trigger_status; // R4
      // Mask uses the low lane only
      if (do_write && aw_addr == `OCFT_ADDR_MASK && w_strb[0])
        mask <= w_data[`OCFT_EV_BITS-1:0];
      // Enable follows control writes
      enable <= next_en;
    end
  end

  // Sticky status; a new event wins over a write-one clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      status <= 3'h0;
      irq    <= 1'b0;
    end else if (ce) begin
      // Write-one clears a bit; an event in the same cycle sets it again
      if (do_write && aw_addr == `OCFT_ADDR_STATUS && w_strb[0])
        status <= (status & ~w_data[`OCFT_EV_BITS-1:0]) | {off_evt, trig_evt, fault_evt};
      else
        status <= status | {off_evt, trig_evt, fault_evt};
      // Registered level, so it trails the status by one cycle
      irq <= |(status & mask);
    end
  end

  // Fault latch and fault-mode exit
  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_fault_flag <= 1'b0;
      fault_mode         <= 1'b0;
    end else if (ce) begin
      // Fault present sets the flag even during a clear
      if (fault_seen)
        channel_fault_flag <= 1'b1;
      else if (flag_clr)
        channel_fault_flag <= 1'b0;
      // Fault mode starts at once and ends only at a period boundary
      if (fault_seen) begin
        fault_mode <= 1'b1;
      end else if (fault_mode && period_end) begin
        // Leave only at a period boundary so a whole pulse resumes
        // In hold mode the flag must be cleared as well as the source gone
        if (!control_2[`OCFT_BIT_FAULT_HOLD_MODE] || !channel_fault_flag)
          fault_mode <= 1'b0; // R1
      end
    end
  end

  // Timebase: triggered or synchronised from the selected source
  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_count          <= {TW{1'b0}};
      timer_trigger_status <= 1'b0;
    end else if (ce) begin
      // A disabled channel keeps its timebase at zero
      if (!enable) begin
        timer_count          <= {TW{1'b0}};
        timer_trigger_status <= 1'b0;
      end else if (trig_sel) begin
        // Trigger mode: held clear until the source fires
        if (timer_trigger_status || src_hit)
          timer_trigger_status <= 1'b1; // R3 R4
        // Count only once triggered
        if (!timer_trigger_status)
          timer_count <= {TW{1'b0}}; // R4
        else
          timer_count <= period_end ? {TW{1'b0}} : timer_count + 1'b1;
      end else begin
        // Sync mode: source restarts the period
        timer_trigger_status <= 1'b0;
        if (src_hit || period_end)
          timer_count <= {TW{1'b0}}; // R3
        else
          timer_count <= timer_count + 1'b1;
      end
    end
  end

  // Pin drive; direction bit first, then fault override
  always @(posedge aclk) begin
    if (!aresetn) begin
      compare_out <= 1'b0;
      compare_oe  <= 1'b0;
      trigger_out <= 1'b0;
    end else if (ce) begin
      // One-cycle trigger out to channels that use this one as a source
      trigger_out <= off_evt; // R7
      if (control_2[`OCFT_BIT_TRIS]) begin
        compare_oe  <= 1'b0; // R5
        compare_out <= 1'b0;
      end else if (fault_mode || fault_seen) begin
        compare_oe  <= ~control_2[`OCFT_BIT_FLTTRI]; // R2
        compare_out <= control_2[`OCFT_BIT_FLTTRI] ? 1'b0 : control_2[`OCFT_BIT_FAULT_DRIVE_LEVEL]; // R2
      end else begin
        compare_oe  <= 1'b1; // R5
        // Normal pulse: high while the count is below the compare value
        compare_out <= (enable & (timer_count < duty)) ^ control_2[`OCFT_BIT_INV];
      end
    end
  end

endmodule // ocft_core

// [tb/ocft_props.sv]
`timescale 1ns/1ps
module ocft_props #(
  parameter NSRC = 32,
  parameter TW   = 16
) (
  input wire            aclk,
  input wire            aresetn,
  input wire [7:0]      s_axi_awaddr,
  input wire            s_axi_awvalid,
  input wire            s_axi_awready,
  input wire [31:0]     s_axi_wdata,
  input wire            s_axi_wvalid,
  input wire            s_axi_wready,
  input wire            fault_in,
  input wire [NSRC-1:0] source_pulse,
  input wire            compare_out,
  input wire            compare_oe,
  input wire            trigger_out,
  input wire [TW-1:0]   timer_count,
  input wire            irq
);
  reg [15:0] con2; // Shadow of control 2, taken at the write handshake
  reg        en;   // Shadow of the channel enable
  // Shadow follows full-word writes only; the bench never uses partial strobes
  always @(posedge aclk) begin
    if (!aresetn) begin
      con2 <= 16'h000C;
      en   <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) begin
      if (s_axi_awaddr == 8'h00) con2 <= s_axi_wdata[15:0];
      if (s_axi_awaddr == 8'h0C) en <= s_axi_wdata[0];
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Fault held with settled setup, so register write latency cannot fire it
  sequence flt_s(bit t);
    (fault_in && con2[13] == t && !con2[5] && $stable(con2)) [*6];
  endsequence
  fault_level_a: assert property (flt_s(0) |-> compare_oe && compare_out == con2[14])
    else $error("fault level not driven");
  fault_tri_a: assert property (flt_s(1) |-> !compare_oe)
    else $error("pin driven during fault");
  hold_fault_a: assert property ($fell(fault_in) && con2[15] && !con2[13] && !con2[5]
    |=> (compare_oe && compare_out == con2[14]) [*8]) else $error("fault hold left early");
  pin_tri_a: assert property (con2[5] && $past(con2[5], 4) |-> !compare_oe)
    else $error("pin driven while tri-stated");
  sync_restart_a: assert property (en && !con2[7] && source_pulse[con2[4:0]] |=> timer_count == 0)
    else $error("sync pulse did not restart timer");
  count_step_a: assert property (timer_count != 0 |-> timer_count == $past(timer_count) + 1'b1)
    else $error("timer moved by other than one");
  off_pulse_a: assert property ($fell(en) |-> ##[1:3] trigger_out ##1 !trigger_out)
    else $error("no single trigger pulse on disable");
  reset_out_a: assert property (disable iff (1'b0) !aresetn |=> !compare_oe && !trigger_out && !irq)
    else $error("outputs active after reset");
endmodule // ocft_props

// [tb/ocft_load.sv]
`timescale 1ns/1ps
// Pin load with a weak pull-down: a released pin settles low
module ocft_load (
  input  wire compare_out,
  input  wire compare_oe,
  output wire pin_level
);
  assign pin_level = compare_oe ? compare_out : 1'b0;
endmodule // ocft_load

// [tb/output_compare_fault_trigger_tb_top.sv]
`timescale 1ns/1ps
module output_compare_fault_trigger_tb_top;
  reg         aclk = 0, aresetn = 0, fault_in = 0;
  reg  [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  reg  [31:0] s_axi_wdata = 0, source_pulse = 0;
  reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        compare_out, compare_oe, trigger_out, irq, pin_level;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] timer_count;
  integer     n_mismatch = 0, compares = 0, cyc = 0, hi = 0;
  always #50 aclk = ~aclk;
  ocft_core dut_u (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .fault_in, .source_pulse, .period(16'h0004), .duty(16'h0002), .compare_out, .compare_oe, .trigger_out,
    .timer_count, .irq);
  ocft_load load_u (.compare_out, .compare_oe, .pin_level);
  task wrap_up;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Each channel is held until its own ready is sampled at an edge
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg ad, dd;
    begin
      ad = 0;
      dd = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (!(ad && dd)) begin
        @(posedge aclk);
        if (s_axi_awready) ad = 1;
        if (s_axi_wready) dd = 1;
        if (ad) s_axi_awvalid <= 0;
        if (dd) s_axi_wvalid <= 0;
      end
      s_axi_bready <= 1;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk(s_axi_bresp, er, "bresp");
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp, input [1:0] er);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 0;
      chk(s_axi_rdata, exp, "rdata");
      chk(s_axi_rresp, er, "rresp");
    end
  endtask
  // Hang guard, well above the roughly 140 cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00, 32'h000C, 0);
    wr(8'h00, 32'hFFFF, 0);
    rd(8'h00, 32'hF1BF, 0);
    chk(pin_level, 0, "pin");
    rd(8'h10, 0, 2);
    wr(8'h10, 1, 2);
    wr(8'h08, 7, 0);
    wr(8'h0C, 1, 0);
    wr(8'h00, 32'h400C, 0);
    source_pulse <= 32'h1000;
    @(posedge aclk);
    source_pulse <= 0;
    fault_in <= 1;
    repeat (8) @(posedge aclk);
    chk({compare_oe, compare_out, irq}, 3'b111, "fault high");
    wr(8'h00, 32'h600C, 0);
    repeat (2) @(posedge aclk);
    chk({compare_oe, pin_level}, 2'b00, "fault tri");
    wr(8'h00, 32'hC00C, 0);
    fault_in <= 0;
    repeat (10) @(posedge aclk);
    rd(8'h0C, 32'h7, 0);
    chk({compare_oe, compare_out}, 2'b11, "held high");
    wr(8'h0C, 3, 0);
    repeat (12) @(posedge aclk);
    rd(8'h0C, 32'h1, 0);
    // Period of five counts, compare value two: two high cycles in any five
    hi = 0;
    repeat (5) begin
      @(posedge aclk);
      hi = hi + compare_out;
    end
    chk(hi, 2, "pulse width");
    wr(8'h04, 7, 0);
    rd(8'h04, 0, 0);
    wr(8'h0C, 0, 0);
    rd(8'h04, 4, 0);
    chk(irq, 1, "irq");
    wr(8'h08, 0, 0);
    @(posedge aclk);
    chk(irq, 0, "irq masked");
    wr(8'h04, 7, 0);
    wr(8'h08, 7, 0);
    wr(8'h00, 32'h008C, 0);
    wr(8'h0C, 1, 0);
    repeat (4) @(posedge aclk);
    chk(timer_count, 0, "held");
    rd(8'h00, 32'h008C, 0);
    source_pulse <= 32'h1000;
    @(posedge aclk);
    source_pulse <= 0;
    repeat (3) @(posedge aclk);
    rd(8'h00, 32'h00CC, 0);
    rd(8'h04, 2, 0);
    chk(irq, 1, "irq trig");
    wrap_up;
  end
endmodule // output_compare_fault_trigger_tb_top
bind ocft_core ocft_props #(.NSRC(NSRC), .TW(TW)) u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .fault_in, .source_pulse, .compare_out,
  .compare_oe, .trigger_out, .timer_count, .irq);
